// *** common/rss_pkg.sv ***
// Purpose: constants and types for the reset source supervisor.
// Assumes: a 20 MHz clock and word registers on an AHB-Lite bus.
// Notes: register offsets are byte addresses within the block.
// Behaviour
// - Programmable low trips, fixed high trip.
// - Monitors stay off until power-on reset ends.
// - Sleep switches monitors on in short bursts.
// - Sleep interrupt: wake first, then flag.
// - Low external reset pin holds reset.
// - External reset resets the chip but not the supervisor.
// - External reset honoured in sleep and hibernate.
// - Software request bit starts a reset.
// - Software reset resets the chip but not the supervisor.
// - Disable bit blocks the software reset.
// - Watchdog resets unless firmware restarts it.
// - Power-on reset leaves watchdog disabled.
// - Watchdog enable sticks until power-on reset.
// - Low monitors may reset instead of interrupt.
// - Status records latest source, cleared by POR.
// - Reset pulse lasts at least 100 ns.
package rss_pkg;
    localparam int RSS_CLK_NS = 50;
    localparam int RSS_PULSE_NS = 100;
    localparam int RSS_PULSE_CYC =
        (RSS_PULSE_NS + RSS_CLK_NS - 1) / RSS_CLK_NS;
    localparam int RSS_AW = 8;
    localparam logic [7:0] RSS_OFS_CTRL = 8'h00;
    localparam logic [7:0] RSS_OFS_STAT = 8'h04;
    localparam logic [7:0] RSS_OFS_MASK = 8'h08;
    localparam logic [7:0] RSS_OFS_WDTO = 8'h0c;
    localparam logic [7:0] RSS_OFS_WDKICK = 8'h10;
    localparam logic [7:0] RSS_OFS_TRIP = 8'h14;
    localparam logic [7:0] RSS_OFS_HIGH = 8'h18;
    localparam logic [1:0] RSS_HT_NONSEQ = 2'h2;
    localparam logic [1:0] RSS_HT_SEQ = 2'h3;
    localparam logic [3:0] RSS_TRIP_MAX = 4'hb;
    localparam logic [15:0] RSS_LOW_BASE_MV = 16'h0a96;
    localparam logic [15:0] RSS_LOW_STEP_MV = 16'h00fa;
    localparam logic [15:0] RSS_HIGH_MV = 16'h1676;

    typedef struct packed {
        logic wdEnable;
        logic swResetRequest;
        logic swResetDisable;
        logic anaLowRstMode;
        logic digLowRstMode;
        logic anaHighEn;
        logic anaLowEn;
        logic digLowEn;
        logic [3:0] anaLowTrip;
        logic [3:0] digLowTrip;
    } rss_ctrl_t;
    localparam int RSS_CTRL_W = $bits(rss_ctrl_t);
    localparam rss_ctrl_t RSS_CTRL_RST = '0;

    typedef struct packed {
        logic wdogRst;
        logic swRst;
        logic extRst;
        logic lvRst;
        logic anaHigh;
        logic anaLow;
        logic digLow;
    } rss_src_t;
    localparam int RSS_SRC_W = $bits(rss_src_t);
    localparam rss_src_t RSS_SRC_RESETS = 7'h78;

    typedef enum logic [1:0] {
        RSS_AWAKE = 2'h0,
        RSS_SLEEP_OFF = 2'h1,
        RSS_SLEEP_ON = 2'h3,
        RSS_WAKING = 2'h2
    } rss_state_t;

    function automatic logic [15:0] rss_trip_mv(input logic [3:0] code);
        rss_trip_mv = 16'(RSS_LOW_BASE_MV + 16'(code) * RSS_LOW_STEP_MV);
    endfunction
endpackage

// *** design/rss_supervisor.sv ***
// Purpose: reset source supervisor with supply monitor control.
// Assumes: comparator flags and pin levels are synchronous to clock.
// Notes: reset_n is the power-on reset; systemReset_n is the chip reset.
`timescale 1ns/100ps
module rss_supervisor
    import rss_pkg::*;
#(
    parameter int WD_W = 24,
    parameter int WD_TIMEOUT_DEF = 20000,
    parameter int BUZZ_OFF_CYC = 1000,
    parameter int BUZZ_ON_CYC = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic externalReset_n,
    input wire logic sleepMode,
    input wire logic digitalSupplyLowIrq,
    input wire logic analogSupplyLowIrq,
    input wire logic analogSupplyHighIrq,
    output logic monitorEnable,
    output logic [3:0] digLowTrip,
    output logic [3:0] anaLowTrip,
    output logic wakeupReq,
    output logic irq,
    output logic systemReset_n
);
    localparam int BZ_W = 16;
    localparam logic [BZ_W-1:0] BZ_OFF = BZ_W'(BUZZ_OFF_CYC);
    localparam logic [BZ_W-1:0] BZ_ON = BZ_W'(BUZZ_ON_CYC);
    localparam logic [WD_W-1:0] WD_DEF = WD_W'(WD_TIMEOUT_DEF);
    localparam logic [7:0] PULSE = 8'(RSS_PULSE_CYC);

    logic [31:0] hrdata_r;
    logic wrPend_r;
    logic [RSS_AW-1:0] wrAddr_r;
    logic addrOk;
    logic wrCtrl;
    logic wrStat;
    logic wrMask;
    logic wrWdto;
    logic wrKick;
    rss_ctrl_t wData;
    rss_ctrl_t ctrl_r;
    rss_src_t stat_r;
    rss_src_t stat_nxt;
    rss_src_t mask_r;
    rss_src_t pend_r;
    rss_src_t irqHits;
    rss_src_t srcSet;
    logic [WD_W-1:0] wdTimeout_r;
    logic [WD_W-1:0] wdCount_r;
    logic [7:0] holdCnt_r;
    logic softHold_r;
    logic rstAsync_n;
    logic rstMeta_r;
    logic sysRst_n_r;
    logic porDone_r;
    rss_state_t state_r;
    logic [BZ_W-1:0] buzzCnt_r;
    logic monEn_r;
    logic wake_r;
    logic irq_r;
    logic digLowHit;
    logic anaLowHit;
    logic anaHighHit;
    logic lvRstEvt;
    logic irqEvt;
    logic swFire;
    logic wdFire;
    logic rstReq;
    logic promote;

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign monitorEnable = monEn_r;
    assign digLowTrip = ctrl_r.digLowTrip;
    assign anaLowTrip = ctrl_r.anaLowTrip;
    assign wakeupReq = wake_r;
    assign irq = irq_r;
    assign systemReset_n = sysRst_n_r;

    // Zero wait states, so hreadyout and hresp are constant OKAY.
    assign addrOk = hsel && hready &&
        (htrans == RSS_HT_NONSEQ || htrans == RSS_HT_SEQ);
    assign wData = rss_ctrl_t'(hwdata[RSS_CTRL_W-1:0]);
    assign wrCtrl = wrPend_r && wrAddr_r == RSS_OFS_CTRL;
    assign wrStat = wrPend_r && wrAddr_r == RSS_OFS_STAT;
    assign wrMask = wrPend_r && wrAddr_r == RSS_OFS_MASK;
    assign wrWdto = wrPend_r && wrAddr_r == RSS_OFS_WDTO;
    assign wrKick = wrPend_r && wrAddr_r == RSS_OFS_WDKICK;

    function automatic logic [31:0] readMux(input logic [RSS_AW-1:0] a);
        unique case (a)
            RSS_OFS_CTRL: readMux = 32'(ctrl_r);
            RSS_OFS_STAT: readMux = 32'(stat_r);
            RSS_OFS_MASK: readMux = 32'(mask_r);
            RSS_OFS_WDTO: readMux = 32'(wdTimeout_r);
            RSS_OFS_WDKICK: readMux = 32'(wdCount_r);
            RSS_OFS_TRIP: readMux = {rss_trip_mv(ctrl_r.anaLowTrip),
                rss_trip_mv(ctrl_r.digLowTrip)};
            RSS_OFS_HIGH: readMux = 32'(RSS_HIGH_MV);
            default: readMux = 32'h0;
        endcase
    endfunction

    // Read data is taken in the address phase, so it stands for the
    // whole data phase; unmapped offsets read zero and ignore writes.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= '0;
            hrdata_r <= 32'h0;
        end else begin
            wrPend_r <= addrOk && hwrite;
            wrAddr_r <= haddr[RSS_AW-1:0];
            hrdata_r <= (addrOk && !hwrite) ?
                readMux(haddr[RSS_AW-1:0]) : 32'h0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= RSS_CTRL_RST;
        end else if (wrCtrl) begin
            ctrl_r <= wData;
            ctrl_r.digLowTrip <= (wData.digLowTrip > RSS_TRIP_MAX) ?
                RSS_TRIP_MAX : wData.digLowTrip;
            ctrl_r.anaLowTrip <= (wData.anaLowTrip > RSS_TRIP_MAX) ?
                RSS_TRIP_MAX : wData.anaLowTrip;
            ctrl_r.swResetRequest <= 1'b0;
            ctrl_r.wdEnable <= ctrl_r.wdEnable | wData.wdEnable;
        end
    end

    // Disable set in the same write also blocks the request.
    assign swFire = wrCtrl && wData.swResetRequest &&
        !ctrl_r.swResetDisable && !wData.swResetDisable;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdTimeout_r <= WD_DEF;
            wdCount_r <= WD_DEF;
        end else begin
            if (wrWdto) begin
                wdTimeout_r <= hwdata[WD_W-1:0];
            end
            // Chip reset reloads the count so a bite cannot repeat.
            if (!sysRst_n_r || !ctrl_r.wdEnable || wrKick || wdFire) begin
                wdCount_r <= wdTimeout_r;
            end else begin
                wdCount_r <= wdCount_r - 1'b1;
            end
        end
    end

    assign wdFire = ctrl_r.wdEnable && sysRst_n_r &&
        wdCount_r == '0;

    assign rstReq = swFire || wdFire || lvRstEvt;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            holdCnt_r <= 8'h0;
            softHold_r <= 1'b0;
        end else begin
            if (rstReq) begin
                holdCnt_r <= PULSE;
            end else if (holdCnt_r != 8'h0) begin
                holdCnt_r <= holdCnt_r - 8'h1;
            end
            softHold_r <= rstReq || holdCnt_r > 8'h1;
        end
    end

    // The pin acts without the clock, so it works in any power mode.
    assign rstAsync_n = reset_n && externalReset_n && !softHold_r;

    always_ff @(posedge clock or negedge rstAsync_n) begin
        if (!rstAsync_n) begin
            rstMeta_r <= 1'b0;
            sysRst_n_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            sysRst_n_r <= rstMeta_r;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            porDone_r <= 1'b0;
        end else if (sysRst_n_r) begin
            porDone_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= RSS_AWAKE;
            buzzCnt_r <= '0;
        end else begin
            unique case (state_r)
                RSS_AWAKE: begin
                    if (sleepMode) begin
                        state_r <= RSS_SLEEP_OFF;
                        buzzCnt_r <= BZ_OFF;
                    end
                end
                RSS_SLEEP_OFF: begin
                    if (!sleepMode) begin
                        state_r <= RSS_AWAKE;
                    end else if (buzzCnt_r == '0) begin
                        state_r <= RSS_SLEEP_ON;
                        buzzCnt_r <= BZ_ON;
                    end else begin
                        buzzCnt_r <= buzzCnt_r - 1'b1;
                    end
                end
                RSS_SLEEP_ON: begin
                    if (!sleepMode) begin
                        state_r <= RSS_AWAKE;
                    end else if (irqEvt) begin
                        state_r <= RSS_WAKING;
                    end else if (buzzCnt_r == '0) begin
                        state_r <= RSS_SLEEP_OFF;
                        buzzCnt_r <= BZ_OFF;
                    end else begin
                        buzzCnt_r <= buzzCnt_r - 1'b1;
                    end
                end
                RSS_WAKING: begin
                    if (!sleepMode) begin
                        state_r <= RSS_AWAKE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            monEn_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            monEn_r <= porDone_r && sysRst_n_r &&
                ((state_r == RSS_AWAKE && !sleepMode) ||
                state_r == RSS_SLEEP_ON);
            wake_r <= (state_r == RSS_SLEEP_ON && irqEvt) ||
                (state_r == RSS_WAKING && sleepMode);
        end
    end

    // Comparator flags mean nothing while the monitors are off.
    assign digLowHit = monEn_r && ctrl_r.digLowEn && digitalSupplyLowIrq;
    assign anaLowHit = monEn_r && ctrl_r.anaLowEn && analogSupplyLowIrq;
    assign anaHighHit = monEn_r && ctrl_r.anaHighEn && analogSupplyHighIrq;
    assign lvRstEvt = (digLowHit && ctrl_r.digLowRstMode) ||
        (anaLowHit && ctrl_r.anaLowRstMode);

    always_comb begin
        irqHits = '0;
        irqHits.digLow = digLowHit && !ctrl_r.digLowRstMode;
        irqHits.anaLow = anaLowHit && !ctrl_r.anaLowRstMode;
        irqHits.anaHigh = anaHighHit;
    end
    assign irqEvt = |irqHits;
    assign promote = state_r == RSS_WAKING && !sleepMode;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pend_r <= '0;
        end else if (promote) begin
            pend_r <= '0;
        end else if (state_r != RSS_AWAKE) begin
            pend_r <= pend_r | irqHits;
        end
    end

    always_comb begin
        srcSet = '0;
        if (state_r == RSS_AWAKE) begin
            srcSet = irqHits;
        end
        if (promote) begin
            srcSet = srcSet | pend_r | irqHits;
        end
        srcSet.extRst = !externalReset_n;
        srcSet.swRst = swFire;
        srcSet.wdogRst = wdFire;
        srcSet.lvRst = lvRstEvt;
    end

    // A new event wins over a write-one clear in the same cycle.
    always_comb begin
        stat_nxt = stat_r;
        if (wrStat) begin
            stat_nxt = stat_nxt & ~rss_src_t'(hwdata[RSS_SRC_W-1:0]);
        end
        if (|(srcSet & RSS_SRC_RESETS)) begin
            stat_nxt = stat_nxt & ~RSS_SRC_RESETS;
        end
        stat_nxt = stat_nxt | srcSet;
    end

    // Status clears only on power-on reset, a write-one clear or, for the reset bits, a newer reset source, so software can read the cause.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stat_r <= '0;
            mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            if (wrMask) begin
                mask_r <= rss_src_t'(hwdata[RSS_SRC_W-1:0]);
            end
            irq_r <= |(stat_r & mask_r);
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_trip_range: assert property (ctrl_r.digLowTrip <= RSS_TRIP_MAX && ctrl_r.anaLowTrip <= RSS_TRIP_MAX)
        else $error("Trip code beyond the top setting.");
    chk_mon_after_por: assert property (!porDone_r |-> !monEn_r)
        else $error("Monitor on before power-on reset finished.");
    chk_buzz_off: assert property ((state_r == RSS_SLEEP_OFF)[*2] |-> !monEn_r)
        else $error("Monitor on outside a sleep burst.");
    chk_wake_first: assert property ((state_r == RSS_SLEEP_ON && irqEvt && sleepMode) |=> wake_r && state_r == RSS_WAKING && !(|(stat_r & ~RSS_SRC_RESETS & ~$past(stat_r))))
        else $error("Sleep interrupt flagged before wakeup.");
    chk_ext_hold: assert property (!externalReset_n |=> !sysRst_n_r)
        else $error("External reset did not hold the chip.");
    chk_pulse_len: assert property ($fell(sysRst_n_r) |-> (!sysRst_n_r)[*2])
        else $error("System reset pulse too short.");
    chk_sw_reset: assert property (swFire |-> ##[1:4] !sysRst_n_r)
        else $error("Software request gave no reset.");
    chk_sw_block: assert property ((wrCtrl && ctrl_r.swResetDisable && !wdFire && !lvRstEvt && holdCnt_r == 8'h0) |=> !softHold_r)
        else $error("Disabled software reset still fired.");
    chk_wd_bite: assert property (wdFire |-> ##[1:4] !sysRst_n_r)
        else $error("Watchdog expiry gave no reset.");
    chk_wd_sticky: assert property (ctrl_r.wdEnable |=> ctrl_r.wdEnable)
        else $error("Watchdog enable was cleared.");
    chk_lv_reset: assert property (lvRstEvt |-> ##[1:4] !sysRst_n_r)
        else $error("Low supply reset mode gave no reset.");
    chk_ext_record: assert property (!externalReset_n |=> stat_r.extRst && !stat_r.swRst)
        else $error("External reset not recorded.");
endmodule

// *** verif/rss_far_model.sv ***
// Purpose: far side of the supervisor: reset pin and supply comparators.
// Assumes: the bench requests pin pulls and trips just after a clock edge.
// Notes: a comparator that is switched off gives no valid level.
`timescale 1ns/100ps
module rss_far_model (
    input wire logic clock,
    input wire logic monitorEnable,
    input wire logic pinLow,
    input wire logic tripDig,
    input wire logic tripAna,
    input wire logic tripHigh,
    output logic externalReset_n,
    output logic digitalSupplyLowIrq,
    output logic analogSupplyLowIrq,
    output logic analogSupplyHighIrq
);
    logic junk_r = 1'b0;

    // Unpowered comparators toggle, so a design that listens to them early
    // picks up false trips.
    always @(posedge clock) begin
        junk_r <= ~junk_r;
    end
    // The pin has a pull-up, so it reads high unless pulled low.
    assign externalReset_n = ~pinLow;
    assign digitalSupplyLowIrq = monitorEnable ? tripDig : junk_r;
    assign analogSupplyLowIrq = monitorEnable ? tripAna : junk_r;
    assign analogSupplyHighIrq = monitorEnable ? tripHigh : junk_r;
endmodule

// *** verif/tb.sv ***
// Purpose: self-checking bench for the reset source supervisor.
// Assumes: a zero-wait slave; watchdog and sleep-off counts are shortened.
// Notes: all expected values are worked out here, never read back.
`timescale 1ns/100ps
module tb;
    import rss_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic sleepMode = 1'b0;
    logic pinLow = 1'b0;
    logic tripDig = 1'b0;
    logic tripAna = 1'b0;
    logic tripHigh = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, externalReset_n, monitorEnable, wakeupReq, irq;
    logic digitalSupplyLowIrq, analogSupplyLowIrq, analogSupplyHighIrq;
    logic systemReset_n;
    logic [3:0] digLowTrip, anaLowTrip, c;
    logic [3:0] codes [4] = '{4'h0, 4'h5, 4'hb, 4'hf};
    logic [15:0] mv;
    int miscompares = 0;
    int num_checks = 0;
    int t;

    always #25 clock = ~clock;

    rss_supervisor #(.WD_TIMEOUT_DEF(50), .BUZZ_OFF_CYC(8), .BUZZ_ON_CYC(4))
    rss_supervisor_inst (.clock(clock), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .externalReset_n(externalReset_n), .sleepMode(sleepMode),
        .digitalSupplyLowIrq(digitalSupplyLowIrq),
        .analogSupplyLowIrq(analogSupplyLowIrq),
        .analogSupplyHighIrq(analogSupplyHighIrq),
        .monitorEnable(monitorEnable), .digLowTrip(digLowTrip),
        .anaLowTrip(anaLowTrip), .wakeupReq(wakeupReq), .irq(irq),
        .systemReset_n(systemReset_n));

    rss_far_model rss_far_model_inst (.clock(clock),
        .monitorEnable(monitorEnable), .pinLow(pinLow), .tripDig(tripDig),
        .tripAna(tripAna), .tripHigh(tripHigh),
        .externalReset_n(externalReset_n),
        .digitalSupplyLowIrq(digitalSupplyLowIrq),
        .analogSupplyLowIrq(analogSupplyLowIrq),
        .analogSupplyHighIrq(analogSupplyHighIrq));

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Called just after a rising edge; returns just after the data phase.
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= RSS_HT_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
        check("hresp", 32'h0, 32'(hresp));
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdm(input string what, input logic [7:0] a,
        input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, exp, q & m);
    endtask

    task automatic rdc(input string what, input logic [7:0] a,
        input logic [31:0] exp);
        rdm(what, a, 32'hffffffff, exp);
    endtask

    function automatic logic pick(input int s);
        return s == 0 ? systemReset_n : s == 1 ? monitorEnable : wakeupReq;
    endfunction

    task automatic await(input string what, input int s, input logic v,
        input int n, output int t);
        t = 0;
        while (pick(s) !== v && t < n) begin
            @(posedge clock);
            t++;
        end
        check(what, 32'(v), 32'(pick(s)));
    endtask

    task automatic rst_pulse(input logic [31:0] st, input int n);
        int t;
        await("sysRstLow", 0, 1'b0, n, t);
        await("sysRstHigh", 0, 1'b1, 30, t);
        check("pulseLen", 32'h1, 32'(t >= RSS_PULSE_CYC));
        rdm("STATUS", RSS_OFS_STAT, 32'h78, st);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        $display("BAD timeout expected end seen hang");
        test_done;
    end

    initial begin
        repeat (10) @(posedge clock);
        check("monEnInRst", 32'h0, 32'(monitorEnable));
        check("sysRstInRst", 32'h0, 32'(systemReset_n));
        reset_n <= 1'b1;
        @(posedge clock);
        rdc("CTRL", RSS_OFS_CTRL, 32'h0);
        rdc("STATUS", RSS_OFS_STAT, 32'h0);
        rdc("WDTO", RSS_OFS_WDTO, 32'h32);
        rdc("WDCNT", RSS_OFS_WDKICK, 32'h32);
        rdc("HIGH", RSS_OFS_HIGH, {16'h0, RSS_HIGH_MV});
        rdc("unmapped", 8'h40, 32'h0);
        await("sysRstUp", 0, 1'b1, 5, t);
        $display("reset values done");
        foreach (codes[i]) begin
            c = codes[i] > RSS_TRIP_MAX ? RSS_TRIP_MAX : codes[i];
            mv = RSS_LOW_BASE_MV + 16'(c) * RSS_LOW_STEP_MV;
            wr(RSS_OFS_CTRL, {24'h0, codes[i], codes[i]});
            rdc("TRIP", RSS_OFS_TRIP, {mv, mv});
            check("digTrip", 32'(c), 32'(digLowTrip));
            check("anaTrip", 32'(c), 32'(anaLowTrip));
        end
        $display("trip settings done");
        wr(RSS_OFS_MASK, 32'h1);
        wr(RSS_OFS_CTRL, 32'h700);
        tripDig <= 1'b1;
        tripAna <= 1'b1;
        tripHigh <= 1'b1;
        repeat (4) @(posedge clock);
        rdc("STATUS", RSS_OFS_STAT, 32'h7);
        check("irqOn", 32'h1, 32'(irq));
        tripDig <= 1'b0;
        tripAna <= 1'b0;
        tripHigh <= 1'b0;
        wr(RSS_OFS_STAT, 32'h1);
        rdc("STATUS", RSS_OFS_STAT, 32'h6);
        check("irqMasked", 32'h0, 32'(irq));
        wr(RSS_OFS_STAT, 32'h7f);
        $display("awake interrupts done");
        // First the disable in the same write, then the stored disable.
        wr(RSS_OFS_CTRL, 32'h6000);
        wr(RSS_OFS_CTRL, 32'h4000);
        repeat (6) @(posedge clock);
        check("noSwRst", 32'h1, 32'(systemReset_n));
        wr(RSS_OFS_CTRL, 32'h4000);
        rst_pulse(32'h20, 12);
        wr(RSS_OFS_CTRL, 32'h900);
        tripDig <= 1'b1;
        repeat (2) @(posedge clock);
        tripDig <= 1'b0;
        rst_pulse(32'h08, 12);
        wr(RSS_OFS_CTRL, 32'h100);
        wr(RSS_OFS_STAT, 32'h7f);
        $display("software and supply resets done");
        // The watchdog is left off across sleep, as software should.
        sleepMode <= 1'b1;
        pinLow <= 1'b1;
        #1;
        check("extRstAsync", 32'h0, 32'(systemReset_n));
        repeat (5) @(posedge clock);
        check("extRstHeld", 32'h0, 32'(systemReset_n));
        pinLow <= 1'b0;
        await("extRstEnd", 0, 1'b1, 4, t);
        rdc("STATUS", RSS_OFS_STAT, 32'h10);
        await("buzzIdle", 1, 1'b0, 12, t);
        await("buzzOn", 1, 1'b1, 14, t);
        await("buzzOff", 1, 1'b0, 12, t);
        check("buzzLen", 32'h5, 32'(t));
        tripDig <= 1'b1;
        await("wake", 2, 1'b1, 20, t);
        tripDig <= 1'b0;
        rdc("STATUS", RSS_OFS_STAT, 32'h10);
        sleepMode <= 1'b0;
        repeat (2) @(posedge clock);
        rdc("STATUS", RSS_OFS_STAT, 32'h11);
        check("irqWake", 32'h1, 32'(irq));
        wr(RSS_OFS_STAT, 32'h7f);
        $display("sleep monitoring done");
        wr(RSS_OFS_WDTO, 32'h14);
        wr(RSS_OFS_WDKICK, 32'h0);
        wr(RSS_OFS_CTRL, 32'h8000);
        repeat (6) begin
            repeat (8) @(posedge clock);
            wr(RSS_OFS_WDKICK, 32'h0);
        end
        check("noWdRst", 32'h1, 32'(systemReset_n));
        wr(RSS_OFS_CTRL, 32'h0);
        rdc("CTRL", RSS_OFS_CTRL, 32'h8000);
        rst_pulse(32'h40, 30);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rdc("CTRL", RSS_OFS_CTRL, 32'h0);
        rdc("STATUS", RSS_OFS_STAT, 32'h0);
        repeat (60) @(posedge clock);
        check("wdOff", 32'h1, 32'(systemReset_n));
        $display("watchdog done");
        test_done;
    end
endmodule
